// ==== can_rx_slot_timestamp_buffer.sv ====
// Receive slots, parking buffer, receive FIFO and stamp capture
`timescale 1ns/10ps
module can_rx_slot_timestamp_buffer (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic rx_valid_in,
    input wire can_rx_pkg::frame_t rx_frame_in,
    output logic rx_ready_out
);

    can_rx_pkg::state_t st_reg;
    can_rx_pkg::state_t st_next;

    logic hit;
    logic [can_rx_pkg::SLOT_W-1:0] idx;
    logic pending;
    logic need_park;
    logic pop_park;
    logic accept;
    logic direct;
    logic push_fifo;
    logic pop_fifo;
    logic req;
    logic done;
    logic [can_rx_pkg::SLOT_W-1:0] head_slot;
    logic [1:0] park_after;

    ////////////////////////////////////////////////////////////////////////
    // Stores a frame and its stamps into a slot
    function automatic can_rx_pkg::slot_t store(
        input can_rx_pkg::slot_t s,
        input can_rx_pkg::frame_t f,
        input logic [31:0] ts,
        input can_rx_pkg::ctrl_t c
    );
        can_rx_pkg::slot_t r;
        r = s;
        r.frame = f;
        r.full = 1'b1;
        if (c.base == can_rx_pkg::BASE_HIGH) begin
            r.stamp = ts[31:16];
        end else begin
            r.stamp = ts[15:0];
        end
        if (c.cap != can_rx_pkg::CAP_OFF) begin
            r.wide = ts;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register read multiplexer
    function automatic logic [31:0] read_word(
        input can_rx_pkg::state_t s,
        input logic [7:0] a
    );
        logic [31:0] r;
        logic [can_rx_pkg::SLOT_W-1:0] k;
        r = 32'h0000_0000;
        k = a[5:4];
        if (a[7:6] == can_rx_pkg::SLOT_REGION) begin
            unique case (a[3:2])
                can_rx_pkg::SLOT_FILTER_W: begin
                    r[can_rx_pkg::FILTER_EN_BIT] = s.slot[k].en;
                    r[can_rx_pkg::ID_W-1:0] = s.slot[k].filter;
                end
                can_rx_pkg::SLOT_DATA_W: r = s.slot[k].frame.data;
                can_rx_pkg::SLOT_STAMP_W: begin
                    r[15:0] = s.slot[k].stamp;
                    r[can_rx_pkg::STAMP_ID_LSB +: can_rx_pkg::ID_W] =
                        s.slot[k].frame.id;
                end
                can_rx_pkg::SLOT_WIDE_W: r = s.slot[k].wide;
            endcase
        end else begin
            case ({a[7:2], 2'b00})
                can_rx_pkg::SECOND_CONTROL_OFS: begin
                    r[can_rx_pkg::CAP_LSB +: 2] = s.ctrl.cap;
                    r[can_rx_pkg::BASE_LSB +: 2] = s.ctrl.base;
                end
                can_rx_pkg::LOCK_OFS: r[can_rx_pkg::SLOTS-1:0] = s.lock;
                can_rx_pkg::STATUS_OFS: begin
                    r[can_rx_pkg::ST_FULL_LSB +: can_rx_pkg::SLOTS] =
                        {s.slot[3].full, s.slot[2].full,
                         s.slot[1].full, s.slot[0].full};
                    r[can_rx_pkg::ST_PARK_LSB +: 2] = s.park_cnt;
                    r[can_rx_pkg::ST_FIFO_LSB +: 3] = s.fifo_cnt;
                end
                can_rx_pkg::TIMER_OFS: r = s.timer;
                can_rx_pkg::FIFO_ID_OFS: begin
                    r[can_rx_pkg::FIFO_NONEMPTY_BIT] = (s.fifo_cnt != 3'h0);
                    r[can_rx_pkg::ID_W-1:0] = s.fifo[s.rptr].id;
                end
                can_rx_pkg::FIFO_DATA_OFS: r = s.fifo[s.rptr].data;
                default: r = 32'h0000_0000;
            endcase
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Frame routing decisions
    always_comb begin
        hit = 1'b0;
        idx = '0;
        pending = 1'b0;
        for (int i = can_rx_pkg::SLOTS - 1; i >= 0; i--) begin
            if (st_reg.slot[i].en && st_reg.slot[i].filter == rx_frame_in.id)
            begin
                hit = 1'b1;
                idx = can_rx_pkg::SLOT_W'(i);
            end
        end
        for (int j = 0; j < can_rx_pkg::PARK_DEPTH; j++) begin
            if (2'(j) < st_reg.park_cnt && st_reg.park[j].slot == idx) begin
                pending = 1'b1;
            end
        end
        head_slot = st_reg.park[0].slot;
        // Parked frames for a slot keep later frames behind them
        need_park = hit && (st_reg.lock[idx] || pending);
        pop_park = (st_reg.park_cnt != 2'h0) && !st_reg.lock[head_slot];
        if (hit) begin
            rx_ready_out = need_park ? (st_reg.park_cnt < can_rx_pkg::PARK_FULL)
                                     : 1'b1;
        end else begin
            rx_ready_out = st_reg.fifo_cnt < can_rx_pkg::FIFO_FULL;
        end
        accept = rx_valid_in && rx_ready_out;
        direct = accept && hit && !need_park;
        push_fifo = accept && !hit;
        req = avs_read_in || avs_write_in;
        done = req && st_reg.ack;
        pop_fifo = done && avs_read_in && st_reg.fifo_cnt != 3'h0 &&
                   {avs_address_in[7:2], 2'b00} == can_rx_pkg::FIFO_DATA_OFS;
        park_after = st_reg.park_cnt - {1'b0, pop_park};
    end

    assign avs_waitrequest_out = req && !st_reg.ack;
    assign avs_readdata_out = st_reg.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [can_rx_pkg::SLOT_W-1:0] k;
        st_next = st_reg;
        k = avs_address_in[5:4];
        st_next.timer = st_reg.timer + 32'h0000_0001;
        st_next.ack = req && !st_reg.ack;
        if (req && !st_reg.ack) begin
            st_next.rdata = read_word(st_reg, avs_address_in);
        end

        // Software side effects first, so hardware sets win
        if (done && avs_write_in) begin
            if (avs_address_in[7:6] == can_rx_pkg::SLOT_REGION) begin
                if (avs_address_in[3:2] == can_rx_pkg::SLOT_FILTER_W) begin
                    if (avs_byteenable_in[0]) begin
                        st_next.slot[k].filter[7:0] = avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        st_next.slot[k].filter[can_rx_pkg::ID_W-1:8] =
                            avs_writedata_in[can_rx_pkg::ID_W-1:8];
                    end
                    if (avs_byteenable_in[3]) begin
                        st_next.slot[k].en =
                            avs_writedata_in[can_rx_pkg::FILTER_EN_BIT];
                    end
                end
            end else if (avs_byteenable_in[0]) begin
                if ({avs_address_in[7:2], 2'b00} ==
                    can_rx_pkg::SECOND_CONTROL_OFS) begin
                    st_next.ctrl.cap =
                        avs_writedata_in[can_rx_pkg::CAP_LSB +: 2];
                    st_next.ctrl.base =
                        avs_writedata_in[can_rx_pkg::BASE_LSB +: 2];
                end else if ({avs_address_in[7:2], 2'b00} ==
                             can_rx_pkg::LOCK_OFS) begin
                    st_next.lock = avs_writedata_in[can_rx_pkg::SLOTS-1:0];
                end
            end
        end
        if (done && avs_read_in &&
            avs_address_in[7:6] == can_rx_pkg::SLOT_REGION &&
            avs_address_in[3:2] == can_rx_pkg::SLOT_DATA_W) begin
            st_next.slot[k].full = 1'b0;
        end

        // Parked head moves with its own stamp
        if (pop_park) begin
            st_next.slot[head_slot] = store(st_next.slot[head_slot],
                st_reg.park[0].frame, st_reg.park[0].stamp,
                st_reg.ctrl);
            st_next.park[0] = st_reg.park[1];
        end
        if (accept && need_park) begin
            st_next.park[park_after[0]].slot = idx;
            st_next.park[park_after[0]].frame = rx_frame_in;
            st_next.park[park_after[0]].stamp = st_reg.timer;
        end
        st_next.park_cnt = park_after + {1'b0, accept && need_park};

        if (direct) begin
            st_next.slot[idx] = store(st_next.slot[idx], rx_frame_in,
                st_reg.timer, st_reg.ctrl);
        end

        // FIFO runs beside the parked move
        if (push_fifo) begin
            st_next.fifo[st_reg.wptr] = rx_frame_in;
            st_next.wptr = st_reg.wptr + 2'h1;
        end
        if (pop_fifo) begin
            st_next.rptr = st_reg.rptr + 2'h1;
        end
        st_next.fifo_cnt = st_reg.fifo_cnt + {2'b00, push_fifo} -
                           {2'b00, pop_fifo};
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_direct_store: assert property (
        direct |=> st_reg.slot[$past(idx)].frame == $past(rx_frame_in))
        else $error("matching frame not stored in slot");

    a_wide_update: assert property (
        direct && st_reg.ctrl.cap != can_rx_pkg::CAP_OFF
        |=> st_reg.slot[$past(idx)].wide == $past(st_reg.timer))
        else $error("wide stamp not updated on store");

    for (genvar g = 0; g < can_rx_pkg::SLOTS; g++) begin : g_lock
        a_locked_slot_hold: assert property (
            st_reg.lock[g]
            |=> st_reg.slot[g].frame == $past(st_reg.slot[g].frame))
            else $error("locked slot overwritten");
    end

    a_park_count: assert property (
        accept && need_park
        |=> st_reg.park_cnt == $past(park_after) + 2'h1
            && st_reg.park_cnt <= can_rx_pkg::PARK_FULL)
        else $error("park buffer count wrong");

    a_park_stamp: assert property (
        accept && need_park && !pop_park
        |=> st_reg.park[$past(st_reg.park_cnt[0])].stamp
            == $past(st_reg.timer))
        else $error("parked stamp lost");

    a_move_frame: assert property (
        pop_park |=> st_reg.slot[$past(head_slot)].frame
                     == $past(st_reg.park[0].frame))
        else $error("parked frame not moved");

    a_move_stamp: assert property (
        pop_park && st_reg.ctrl.cap != can_rx_pkg::CAP_OFF
        |=> st_reg.slot[$past(head_slot)].wide
            == $past(st_reg.park[0].stamp))
        else $error("parked stamp not moved");

    a_fifo_with_move: assert property (
        pop_park && push_fifo && !pop_fifo
        |=> st_reg.fifo_cnt == $past(st_reg.fifo_cnt) + 3'h1)
        else $error("fifo frame lost during move");

    a_base_high: assert property (
        direct && st_reg.ctrl.base == can_rx_pkg::BASE_HIGH
        |=> st_reg.slot[$past(idx)].stamp == $past(st_reg.timer[31:16]))
        else $error("high stamp half wrong");

    a_base_low: assert property (
        direct && st_reg.ctrl.base == can_rx_pkg::BASE_LOW
        |=> st_reg.slot[$past(idx)].stamp == $past(st_reg.timer[15:0]))
        else $error("low stamp half wrong");

    a_fifo_order: assert property (
        push_fifo |=> st_reg.fifo[$past(st_reg.wptr)] == $past(rx_frame_in)
                      && st_reg.wptr == $past(st_reg.wptr) + 2'h1)
        else $error("fifo order broken");

endmodule

// ==== can_rx_pkg.sv ====
// Constants and types shared by the receive slot and stamp buffer
package can_rx_pkg;

    localparam int SLOTS = 4;
    localparam int SLOT_W = 2;
    localparam int PARK_DEPTH = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW = 2;
    localparam int ID_W = 11;

    localparam logic [1:0] PARK_FULL = 2'h2;
    localparam logic [2:0] FIFO_FULL = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets, slot region code and slot word selects
    localparam logic [7:0] SECOND_CONTROL_OFS = 8'h00;
    localparam logic [7:0] LOCK_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] TIMER_OFS = 8'h0C;
    localparam logic [7:0] FIFO_ID_OFS = 8'h10;
    localparam logic [7:0] FIFO_DATA_OFS = 8'h14;
    localparam logic [1:0] SLOT_REGION = 2'h1;
    localparam logic [1:0] SLOT_FILTER_W = 2'h0;
    localparam logic [1:0] SLOT_DATA_W = 2'h1;
    localparam logic [1:0] SLOT_STAMP_W = 2'h2;
    localparam logic [1:0] SLOT_WIDE_W = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CAP_LSB = 0;
    localparam int BASE_LSB = 2;
    localparam int FILTER_EN_BIT = 31;
    localparam int ST_FULL_LSB = 0;
    localparam int ST_PARK_LSB = 4;
    localparam int ST_FIFO_LSB = 8;
    localparam int STAMP_ID_LSB = 16;
    localparam int FIFO_NONEMPTY_BIT = 31;

    ////////////////////////////////////////////////////////////////////////
    // Setting encodings and reset values
    localparam logic [1:0] CAP_OFF = 2'h0;
    localparam logic [1:0] BASE_LOW = 2'h1;
    localparam logic [1:0] BASE_HIGH = 2'h2;
    localparam logic [1:0] CAP_RST = 2'h0;
    localparam logic [1:0] BASE_RST = 2'h0;
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [31:0] data;
    } frame_t;

    typedef struct packed {
        logic en;
        logic [ID_W-1:0] filter;
        frame_t frame;
        logic [15:0] stamp;
        logic [31:0] wide;
        logic full;
    } slot_t;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        frame_t frame;
        logic [31:0] stamp;
    } park_t;

    typedef struct packed {
        logic [1:0] cap;
        logic [1:0] base;
    } ctrl_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic [SLOTS-1:0] lock;
        slot_t [SLOTS-1:0] slot;
        park_t [PARK_DEPTH-1:0] park;
        logic [1:0] park_cnt;
        frame_t [FIFO_DEPTH-1:0] fifo;
        logic [FIFO_AW-1:0] wptr;
        logic [FIFO_AW-1:0] rptr;
        logic [2:0] fifo_cnt;
        logic [31:0] timer;
        logic ack;
        logic [31:0] rdata;
    } state_t;

endpackage

// ==== can_rx_src_model.sv ====
// Receive core model that offers frames to the block
`timescale 1ns/10ps
module can_rx_src_model (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic rx_ready_in,
    output logic rx_valid_out,
    output can_rx_pkg::frame_t rx_frame_out
);
    logic [31:0] tick_reg;
    logic [31:0] last_stamp;

    initial begin
        rx_valid_out = 1'b0;
        rx_frame_out = '0;
        last_stamp = 32'h0;
    end

    // Mirrors the block's free-running stamp timer
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_reg <= 32'h0;
        end else begin
            tick_reg <= tick_reg + 32'h1;
        end
    end

    // Offer held until taken; gives up after max_wait edges
    task automatic send(input logic [10:0] id, input logic [31:0] data,
                        input int max_wait, output logic taken);
        int n;
        taken = 1'b0;
        @(posedge clk_in);
        rx_valid_out <= 1'b1;
        rx_frame_out <= {id, data};
        for (n = 0; n < max_wait && !taken; n++) begin
            @(posedge clk_in);
            if (rx_ready_in === 1'b1) begin
                taken = 1'b1;
                last_stamp = tick_reg;
            end
        end
        rx_valid_out <= 1'b0;
        rx_frame_out <= ~{id, data};
    endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the receive slot and stamp buffer
`timescale 1ns/10ps
module tb_top;
    logic clk_in;
    logic sys_rst_in;
    logic [7:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic rx_valid_in;
    can_rx_pkg::frame_t rx_frame_in;
    logic rx_ready_out;
    int failures;
    int samples_checked;
    int cycles;
    logic [31:0] rd;
    logic [31:0] st;
    logic ok;

    can_rx_slot_timestamp_buffer i_dut (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .rx_valid_in(rx_valid_in),
        .rx_frame_in(rx_frame_in),
        .rx_ready_out(rx_ready_out)
    );

    can_rx_src_model i_src (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .rx_ready_in(rx_ready_out),
        .rx_valid_out(rx_valid_in),
        .rx_frame_out(rx_frame_in)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", samples_checked,
                 failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus_req(input logic [7:0] a, input logic wr,
                           input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_writedata_in <= wd;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_req(a, 1'b1, d, q);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus_req(a, 1'b0, 32'h0, rd);
        check(rd, exp);
    endtask

    // Unlock, then let the parked frames settle into the slot
    task automatic unlock();
        wr(can_rx_pkg::LOCK_OFS, 32'h0);
        repeat (3) @(posedge clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        sys_rst_in = 1'b1;
        avs_address_in = 8'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hF;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rchk(can_rx_pkg::SECOND_CONTROL_OFS, 32'h0);
        rchk(can_rx_pkg::STATUS_OFS, 32'h0);
        wr(8'h30, 32'hFFFF_FFFF);
        rchk(8'h30, 32'h0);
        // Capture off, high half base; slot 0 and slot 1 filters
        wr(can_rx_pkg::SECOND_CONTROL_OFS, 32'h8);
        wr(8'h40, 32'h8000_0123);
        wr(8'h50, 32'h8000_0200);
        i_src.send(11'h200, 32'h1111_1111, 20, ok);
        rchk(8'h54, 32'h1111_1111);
        rchk(8'h5C, 32'h0);
        rchk(8'h58, 32'h0200_0000);
        // Capture on, low half base
        wr(can_rx_pkg::SECOND_CONTROL_OFS, 32'h5);
        i_src.send(11'h123, 32'hA0A0_A0A0, 20, ok);
        st = i_src.last_stamp;
        rchk(8'h44, 32'hA0A0_A0A0);
        rchk(8'h4C, st);
        rchk(8'h48, {16'h0123, st[15:0]});
        // One parked frame while slot 0 is locked
        wr(can_rx_pkg::LOCK_OFS, 32'h1);
        i_src.send(11'h123, 32'hB0B0_B0B0, 20, ok);
        st = i_src.last_stamp;
        rchk(8'h44, 32'hA0A0_A0A0);
        rchk(can_rx_pkg::STATUS_OFS, 32'h0000_0010);
        // FIFO frame lands in the cycle the parked frame moves
        fork
            unlock();
            begin
                repeat (2) @(posedge clk_in);
                i_src.send(11'h055, 32'hF1F1_F1F1, 20, ok);
            end
        join
        rchk(can_rx_pkg::STATUS_OFS, 32'h0000_0101);
        rchk(8'h44, 32'hB0B0_B0B0);
        rchk(8'h4C, st);
        rchk(8'h48, {16'h0123, st[15:0]});
        // Fill the park buffer until it refuses
        wr(can_rx_pkg::LOCK_OFS, 32'h1);
        i_src.send(11'h123, 32'hC0C0_C0C0, 20, ok);
        i_src.send(11'h123, 32'hD0D0_D0D0, 20, ok);
        st = i_src.last_stamp;
        i_src.send(11'h123, 32'hE0E0_E0E0, 10, ok);
        check({31'h0, ok}, 32'h0);
        i_src.send(11'h066, 32'hF2F2_F2F2, 20, ok);
        check({31'h0, ok}, 32'h1);
        rchk(can_rx_pkg::STATUS_OFS, 32'h0000_0220);
        rchk(can_rx_pkg::FIFO_ID_OFS, 32'h8000_0055);
        rchk(can_rx_pkg::FIFO_DATA_OFS, 32'hF1F1_F1F1);
        rchk(can_rx_pkg::FIFO_ID_OFS, 32'h8000_0066);
        rchk(can_rx_pkg::FIFO_DATA_OFS, 32'hF2F2_F2F2);
        rchk(can_rx_pkg::FIFO_ID_OFS, 32'h0);
        unlock();
        rchk(can_rx_pkg::STATUS_OFS, 32'h0000_0001);
        rchk(8'h44, 32'hD0D0_D0D0);
        rchk(8'h4C, st);
        give_verdict();
    end
endmodule
